// ### design/cad_decoder.sv
// instruction decode and effective-address generation
// Function
// - immediate: two bytes, operand at pc plus one
// - direct: second byte is the address, page 0 only
// - extended: three bytes, next two bytes are full address
// - relative: two bytes, taken target pc+2+signed offset, else pc+2
// - taken branch reaches 126 below to 129 above itself
// - indexed no offset: one byte, address is index register
// - indexed 8-bit: two bytes, offset plus index up to 510
// - indexed 16-bit: three bytes, offset plus index anywhere
// - bit set/clear: page-0 address byte, read-modify-write of bit
// - bit set/clear never writes port direction registers
// - bit test: three bytes, page-0 byte, low opcode bits, offset
// - bit test loads carry with tested bit always
// - implied: one byte, no effective address
// - test-flags reads only; other read-modify-write ops write back
// - jump and call load pc with effective address; call pushes
// - high nibble selects mode with listed cycle counts
// - low nibble selects register/memory operation
// - bit test against accumulator changes flags only
// - branches take 2 untaken, 3 taken; always-branch takes 3
// - bit test-and-branch takes 4 untaken, 5 taken
`timescale 1ns/1ps
module cad_decoder #(
  parameter logic [7:0] DDR_LO = cad_pkg::CAD_DDR_LO,
  parameter logic [7:0] DDR_HI = cad_pkg::CAD_DDR_HI
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] pc,
  input wire logic [7:0] index_reg,
  input wire logic flag_half,
  input wire logic flag_irq_mask,
  input wire logic flag_neg,
  input wire logic flag_zero,
  input wire logic flag_carry,
  input wire logic irq_pin,
  input wire logic [7:0] tested_byte,
  output logic dec_valid,
  output cad_pkg::cad_mode_e dec_mode,
  output logic [3:0] dec_op,
  output logic [1:0] instr_len,
  output logic [3:0] cycle_count,
  output logic [15:0] effective_addr,
  output logic [15:0] next_pc,
  output logic pc_load,
  output logic branch_taken,
  output logic mem_read,
  output logic mem_write,
  output logic acc_write,
  output logic index_write,
  output logic push_return,
  output logic [7:0] bit_mask,
  output logic bit_value,
  output logic carry_load,
  output logic carry_value,
  output logic undefined_op
);
  // pin synchroniser: only irq_level is read by logic
  logic irq_meta;
  logic irq_level;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_meta <= 1'b0;
      irq_level <= 1'b0;
    end else begin
      irq_meta <= irq_pin;
      irq_level <= irq_meta;
    end
  end

  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];

  // effective address candidates
  wire [15:0] ea_imm = pc + 16'h0001;
  wire [15:0] ea_dir = {8'h00, operand1};
  wire [15:0] ea_ext = {operand1, operand2};
  wire [15:0] ea_idx0 = {8'h00, index_reg};
  // zero-extended offsets; 8-bit form stops at 510 by construction
  wire [15:0] ea_idx1 = {8'h00, operand1} + {8'h00, index_reg};
  wire [15:0] ea_idx2 = {operand1, operand2} + {8'h00, index_reg};
  wire [15:0] rel_off = {{8{operand1[7]}}, operand1};
  wire [15:0] rel_target = pc + cad_pkg::CAD_REL_STEP + rel_off;
  wire [15:0] btb_off = {{8{operand2[7]}}, operand2};
  wire [15:0] btb_target = pc + cad_pkg::CAD_BTB_STEP + btb_off;
  wire [15:0] rel_dist = rel_target - pc;

  // branch condition: even opcode tests base, odd inverts it
  logic rel_base;
  always_comb begin
    case (opcode[3:1])
      3'h0: rel_base = 1'b1;
      3'h1: rel_base = ~(flag_carry | flag_zero);
      3'h2: rel_base = ~flag_carry;
      3'h3: rel_base = ~flag_zero;
      3'h4: rel_base = ~flag_half;
      3'h5: rel_base = ~flag_neg;
      3'h6: rel_base = ~flag_irq_mask;
      3'h7: rel_base = ~irq_level;
      default: rel_base = 1'b0;
    endcase
  end
  wire rel_cond = rel_base ^ opcode[0];

  wire tested_bit = tested_byte[opcode[3:1]];
  wire btb_taken = opcode[0] ? ~tested_bit : tested_bit;
  wire [7:0] sel_mask = 8'h01 << opcode[3:1];
  // direction registers are not legal targets of bit set/clear
  wire bsc_blocked = (operand1 >= DDR_LO) && (operand1 <= DDR_HI);

  // register/memory group decode
  wire rm_grp = hi >= cad_pkg::CAD_HI_RM_IMM;
  wire rm_imm = hi == cad_pkg::CAD_HI_RM_IMM;
  wire rm_store = (lo == cad_pkg::CAD_OP_STORE_ACC) ||
                  (lo == cad_pkg::CAD_OP_STORE_INDEX);
  wire rm_jump = lo == cad_pkg::CAD_OP_JUMP;
  wire rm_call = lo == cad_pkg::CAD_OP_CALL;
  // no immediate store or jump exists; A-D is the relative call
  wire rm_defined = !(rm_imm && (rm_store || rm_jump || rm_call));
  cad_pkg::cad_mode_e rm_mode;
  logic [15:0] rm_ea;
  logic [1:0] rm_len;
  logic [3:0] rm_base;
  always_comb begin
    case (hi)
      cad_pkg::CAD_HI_RM_IMM: begin
        rm_mode = cad_pkg::CAD_M_IMM;
        rm_ea = ea_imm;
        rm_len = cad_pkg::CAD_LEN2;
        rm_base = cad_pkg::CAD_CYC_IMM;
      end
      cad_pkg::CAD_HI_RM_DIR: begin
        rm_mode = cad_pkg::CAD_M_DIRECT;
        rm_ea = ea_dir;
        rm_len = cad_pkg::CAD_LEN2;
        rm_base = cad_pkg::CAD_CYC_DIR;
      end
      cad_pkg::CAD_HI_RM_EXT: begin
        rm_mode = cad_pkg::CAD_M_EXT;
        rm_ea = ea_ext;
        rm_len = cad_pkg::CAD_LEN3;
        rm_base = cad_pkg::CAD_CYC_EXT;
      end
      cad_pkg::CAD_HI_RM_IDX2: begin
        rm_mode = cad_pkg::CAD_M_IDX2;
        rm_ea = ea_idx2;
        rm_len = cad_pkg::CAD_LEN3;
        rm_base = cad_pkg::CAD_CYC_IDX2;
      end
      cad_pkg::CAD_HI_RM_IDX1: begin
        rm_mode = cad_pkg::CAD_M_IDX1;
        rm_ea = ea_idx1;
        rm_len = cad_pkg::CAD_LEN2;
        rm_base = cad_pkg::CAD_CYC_IDX1;
      end
      default: begin
        rm_mode = cad_pkg::CAD_M_IDX0;
        rm_ea = ea_idx0;
        rm_len = cad_pkg::CAD_LEN1;
        rm_base = cad_pkg::CAD_CYC_IDX0;
      end
    endcase
  end
  wire rm_x0 = hi == cad_pkg::CAD_HI_RM_IDX0;
  wire rm_call_plus = rm_x0 || (hi == cad_pkg::CAD_HI_RM_DIR) ||
                      (hi == cad_pkg::CAD_HI_RM_EXT);
  // store adds one, jump saves one except no-offset, call per mode
  wire [3:0] rm_cyc = rm_store ? rm_base + 4'h1 :
                      rm_jump ? (rm_x0 ? rm_base : rm_base - 4'h1) :
                      (rm_call && rm_call_plus) ? rm_base + 4'h1 : rm_base;

  // read/modify/write group decode
  wire rmw_grp = (hi >= cad_pkg::CAD_HI_RMW_DIR) &&
                 (hi <= cad_pkg::CAD_HI_RMW_IDX0);
  wire rmw_mem = (hi == cad_pkg::CAD_HI_RMW_DIR) ||
                 (hi == cad_pkg::CAD_HI_RMW_IDX1) ||
                 (hi == cad_pkg::CAD_HI_RMW_IDX0);
  wire rmw_tst = lo == cad_pkg::CAD_OP_TEST_FLAGS;
  wire rmw_two = (hi == cad_pkg::CAD_HI_RMW_DIR) ||
                 (hi == cad_pkg::CAD_HI_RMW_IDX1);
  wire [15:0] rmw_ea = (hi == cad_pkg::CAD_HI_RMW_DIR) ? ea_dir :
                       (hi == cad_pkg::CAD_HI_RMW_IDX1) ? ea_idx1 :
                       (hi == cad_pkg::CAD_HI_RMW_IDX0) ? ea_idx0 : 16'h0000;
  wire [3:0] rmw_cyc = (hi == cad_pkg::CAD_HI_RMW_DIR) ?
                       cad_pkg::CAD_CYC_RMW_DIR :
                       (hi == cad_pkg::CAD_HI_RMW_IDX1) ?
                       cad_pkg::CAD_CYC_RMW_IDX1 :
                       (hi == cad_pkg::CAD_HI_RMW_IDX0) ?
                       cad_pkg::CAD_CYC_RMW_IDX0 : cad_pkg::CAD_CYC_RMW_REG;

  cad_pkg::cad_mode_e next_mode;
  logic [1:0] next_len;
  logic [3:0] next_cyc;
  logic [15:0] next_ea;
  logic [15:0] next_npc;
  logic next_taken;
  logic next_pcld;
  logic next_rd;
  logic next_wr;
  logic next_accw;
  logic next_idxw;
  logic next_push;
  logic [7:0] next_mask;
  logic next_bitv;
  logic next_cld;
  logic next_cval;
  logic next_undef;
  always_comb begin
    next_mode = cad_pkg::CAD_M_UNDEF;
    next_len = cad_pkg::CAD_LEN1;
    next_cyc = cad_pkg::CAD_CYC_UNDEF;
    next_ea = 16'h0000;
    next_npc = 16'h0000;
    next_taken = 1'b0;
    next_pcld = 1'b0;
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_accw = 1'b0;
    next_idxw = 1'b0;
    next_push = 1'b0;
    next_mask = 8'h00;
    next_bitv = 1'b0;
    next_cld = 1'b0;
    next_cval = 1'b0;
    next_undef = 1'b1;
    if (hi == cad_pkg::CAD_HI_BITTEST) begin
      next_undef = 1'b0;
      next_mode = cad_pkg::CAD_M_BIT_TB;
      next_len = cad_pkg::CAD_LEN3;
      next_ea = ea_dir;
      next_rd = 1'b1;
      next_mask = sel_mask;
      next_cld = 1'b1;
      next_cval = tested_bit;
      next_taken = btb_taken;
      next_pcld = btb_taken;
      next_npc = btb_target;
      next_cyc = btb_taken ? cad_pkg::CAD_CYC_BTB_T :
                 cad_pkg::CAD_CYC_BTB_NT;
    end else if (hi == cad_pkg::CAD_HI_BITSC) begin
      next_undef = 1'b0;
      next_mode = cad_pkg::CAD_M_BIT_SC;
      next_len = cad_pkg::CAD_LEN2;
      next_ea = ea_dir;
      next_rd = ~bsc_blocked;
      next_wr = ~bsc_blocked;
      next_mask = sel_mask;
      next_bitv = ~opcode[0];
      next_cyc = cad_pkg::CAD_CYC_BSC;
    end else if (hi == cad_pkg::CAD_HI_REL ||
                 opcode == cad_pkg::CAD_OPC_BSR) begin
      next_undef = 1'b0;
      next_mode = cad_pkg::CAD_M_REL;
      next_len = cad_pkg::CAD_LEN2;
      next_ea = rel_target;
      next_npc = rel_target;
      if (opcode == cad_pkg::CAD_OPC_BSR) begin
        next_taken = 1'b1;
        next_pcld = 1'b1;
        next_push = 1'b1;
        next_cyc = cad_pkg::CAD_CYC_BSR;
      end else begin
        next_taken = rel_cond;
        next_pcld = rel_cond;
        next_cyc = rel_cond ? cad_pkg::CAD_CYC_BR_T :
                   cad_pkg::CAD_CYC_BR_NT;
      end
    end else if (rmw_grp && cad_pkg::CAD_RMW_DEFINED[lo]) begin
      next_undef = 1'b0;
      next_mode = (hi == cad_pkg::CAD_HI_RMW_DIR) ? cad_pkg::CAD_M_DIRECT :
                  (hi == cad_pkg::CAD_HI_RMW_IDX1) ? cad_pkg::CAD_M_IDX1 :
                  (hi == cad_pkg::CAD_HI_RMW_IDX0) ? cad_pkg::CAD_M_IDX0 :
                  cad_pkg::CAD_M_IMPLIED;
      next_len = rmw_two ? cad_pkg::CAD_LEN2 : cad_pkg::CAD_LEN1;
      next_ea = rmw_ea;
      next_cyc = rmw_cyc;
      next_rd = rmw_mem;
      next_wr = rmw_mem && !rmw_tst;
      next_accw = (hi == cad_pkg::CAD_HI_RMW_A) && !rmw_tst;
      next_idxw = (hi == cad_pkg::CAD_HI_RMW_X) && !rmw_tst;
    end else if (opcode == cad_pkg::CAD_OPC_RTI ||
                 opcode == cad_pkg::CAD_OPC_RTS ||
                 opcode == cad_pkg::CAD_OPC_SWI) begin
      // stack sequencing lives outside; only the class is given here
      next_undef = 1'b0;
      next_mode = cad_pkg::CAD_M_IMPLIED;
      next_push = opcode == cad_pkg::CAD_OPC_SWI;
      next_cyc = (opcode == cad_pkg::CAD_OPC_RTI) ? cad_pkg::CAD_CYC_RTI :
                 (opcode == cad_pkg::CAD_OPC_RTS) ? cad_pkg::CAD_CYC_RTS :
                 cad_pkg::CAD_CYC_SWI;
    end else if (hi == cad_pkg::CAD_HI_CTRL9 &&
                 cad_pkg::CAD_CTRL9_DEFINED[lo]) begin
      next_undef = 1'b0;
      next_mode = cad_pkg::CAD_M_IMPLIED;
      next_cyc = cad_pkg::CAD_CYC_CTRL;
      next_accw = opcode == cad_pkg::CAD_OPC_TXA;
      next_idxw = opcode == cad_pkg::CAD_OPC_TAX;
    end else if (rm_grp && rm_defined) begin
      next_undef = 1'b0;
      next_mode = rm_mode;
      next_len = rm_len;
      next_ea = rm_ea;
      next_cyc = rm_cyc;
      next_rd = !(rm_store || rm_jump || rm_call);
      next_wr = rm_store;
      // compares and the bit test leave the accumulator alone
      next_accw = cad_pkg::CAD_ACC_WRITE_OPS[lo];
      next_idxw = lo == cad_pkg::CAD_OP_LOAD_INDEX;
      next_pcld = rm_jump || rm_call;
      next_push = rm_call;
      next_npc = rm_ea;
    end
    if (!next_pcld) begin
      next_npc = pc + {14'h0000, next_len};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
      dec_mode <= cad_pkg::CAD_M_UNDEF;
      dec_op <= 4'h0;
      instr_len <= 2'h0;
      cycle_count <= 4'h0;
      effective_addr <= 16'h0000;
      next_pc <= 16'h0000;
      pc_load <= 1'b0;
      branch_taken <= 1'b0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      acc_write <= 1'b0;
      index_write <= 1'b0;
      push_return <= 1'b0;
      bit_mask <= 8'h00;
      bit_value <= 1'b0;
      carry_load <= 1'b0;
      carry_value <= 1'b0;
      undefined_op <= 1'b0;
    end else begin
      dec_valid <= fetch_valid;
      dec_mode <= next_mode;
      dec_op <= lo;
      instr_len <= next_len;
      cycle_count <= next_cyc;
      effective_addr <= next_ea;
      next_pc <= next_npc;
      pc_load <= next_pcld;
      branch_taken <= next_taken;
      mem_read <= next_rd;
      mem_write <= next_wr;
      acc_write <= next_accw;
      index_write <= next_idxw;
      push_return <= next_push;
      bit_mask <= next_mask;
      bit_value <= next_bitv;
      carry_load <= next_cld;
      carry_value <= next_cval;
      undefined_op <= next_undef;
    end
  end

  AST_IMM_EA: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && opcode == 8'hA6 |=> effective_addr == $past(ea_imm)
    && instr_len == 2'h2 && mem_read)
    else $error("immediate address or length wrong");
  AST_DIR_EA: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && opcode == 8'hB6 |=> effective_addr[15:8] == 8'h00
    && effective_addr[7:0] == $past(operand1))
    else $error("direct address not operand byte");
  AST_REL_PC: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && hi == 4'h2 |=> next_pc ==
    (branch_taken ? $past(rel_target) : $past(pc) + 16'h0002))
    else $error("relative next pc wrong");
  AST_REL_SPAN: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && hi == 4'h2 |-> rel_dist <= 16'h0081
    || rel_dist >= 16'hFF81)
    else $error("branch reach out of span");
  AST_IDX1_LIMIT: assert property (@(posedge mclk) disable iff (sys_rst)
    dec_valid && dec_mode == cad_pkg::CAD_M_IDX1 |->
    effective_addr <= 16'h01FF)
    else $error("8-bit indexed address above 511");
  AST_BSC_DDR: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && hi == 4'h1 && bsc_blocked |=> !mem_write)
    else $error("bit set/clear wrote a direction register");
  AST_BTB_CARRY: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && hi == 4'h0 |=> carry_load
    && carry_value == $past(tested_bit) && instr_len == 2'h3)
    else $error("bit test carry not tested bit");
  AST_TST_NOWB: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && rmw_grp && lo == 4'hD |=> !mem_write
    && !acc_write && !index_write)
    else $error("test-flags wrote back");
  AST_JUMP_PC: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && opcode == 8'hCC |=> pc_load && !push_return
    && next_pc == effective_addr && next_pc == $past(ea_ext))
    else $error("jump target not effective address");
  AST_ADC_CYC: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && lo == 4'h9 && rm_grp |=> cycle_count ==
    ($past(hi) == 4'hD ? 4'h5 : $past(hi) == 4'hB ? 4'h3 :
    $past(hi) == 4'hC || $past(hi) == 4'hE ? 4'h4 : 4'h2))
    else $error("add-with-carry cycle count wrong");
  AST_BIT_NOACC: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && rm_grp && lo == 4'h5 |=> !acc_write && mem_read)
    else $error("bit test changed accumulator");
  AST_BR_CYC: assert property (@(posedge mclk) disable iff (sys_rst)
    dec_valid && dec_mode == cad_pkg::CAD_M_REL && !push_return |->
    cycle_count == (branch_taken ? 4'h3 : 4'h2))
    else $error("branch cycle count wrong");
  AST_BTB_CYC: assert property (@(posedge mclk) disable iff (sys_rst)
    dec_valid && dec_mode == cad_pkg::CAD_M_BIT_TB |->
    cycle_count == (branch_taken ? 4'h5 : 4'h4))
    else $error("bit test branch cycle count wrong");
  AST_UNDEF_NOP: assert property (@(posedge mclk) disable iff (sys_rst)
    fetch_valid && opcode == 8'h31 |=> undefined_op && cycle_count == 4'h1
    && !mem_write && !pc_load && next_pc == $past(pc) + 16'h0001)
    else $error("undefined opcode not a no-operation");
endmodule

// ### design/cad_pkg.sv
// shared constants and types for the addressing decoder
package cad_pkg;
  typedef enum logic [3:0] {
    CAD_M_IMPLIED = 4'h0,
    CAD_M_IMM = 4'h1,
    CAD_M_DIRECT = 4'h2,
    CAD_M_EXT = 4'h3,
    CAD_M_REL = 4'h4,
    CAD_M_IDX0 = 4'h5,
    CAD_M_IDX1 = 4'h6,
    CAD_M_IDX2 = 4'h7,
    CAD_M_BIT_SC = 4'h8,
    CAD_M_BIT_TB = 4'h9,
    CAD_M_UNDEF = 4'hA
  } cad_mode_e;
  // opcode high nibble groups
  localparam logic [3:0] CAD_HI_BITTEST = 4'h0;
  localparam logic [3:0] CAD_HI_BITSC = 4'h1;
  localparam logic [3:0] CAD_HI_REL = 4'h2;
  localparam logic [3:0] CAD_HI_RMW_DIR = 4'h3;
  localparam logic [3:0] CAD_HI_RMW_A = 4'h4;
  localparam logic [3:0] CAD_HI_RMW_X = 4'h5;
  localparam logic [3:0] CAD_HI_RMW_IDX1 = 4'h6;
  localparam logic [3:0] CAD_HI_RMW_IDX0 = 4'h7;
  localparam logic [3:0] CAD_HI_CTRL8 = 4'h8;
  localparam logic [3:0] CAD_HI_CTRL9 = 4'h9;
  localparam logic [3:0] CAD_HI_RM_IMM = 4'hA;
  localparam logic [3:0] CAD_HI_RM_DIR = 4'hB;
  localparam logic [3:0] CAD_HI_RM_EXT = 4'hC;
  localparam logic [3:0] CAD_HI_RM_IDX2 = 4'hD;
  localparam logic [3:0] CAD_HI_RM_IDX1 = 4'hE;
  localparam logic [3:0] CAD_HI_RM_IDX0 = 4'hF;
  // register/memory and read-modify-write test-flags operation codes (low nibble)
  localparam logic [3:0] CAD_OP_BIT_TEST = 4'h5;
  localparam logic [3:0] CAD_OP_STORE_ACC = 4'h7;
  localparam logic [3:0] CAD_OP_JUMP = 4'hC;
  localparam logic [3:0] CAD_OP_CALL = 4'hD;
  localparam logic [3:0] CAD_OP_LOAD_INDEX = 4'hE;
  localparam logic [3:0] CAD_OP_STORE_INDEX = 4'hF;
  localparam logic [3:0] CAD_OP_TEST_FLAGS = 4'hD;
  // per-low-nibble masks
  localparam logic [15:0] CAD_ACC_WRITE_OPS = 16'h0F55;
  localparam logic [15:0] CAD_RMW_DEFINED = 16'hB7D9;
  localparam logic [15:0] CAD_CTRL9_DEFINED = 16'hBF80;
  // single opcodes
  localparam logic [7:0] CAD_OPC_RTI = 8'h80;
  localparam logic [7:0] CAD_OPC_RTS = 8'h81;
  localparam logic [7:0] CAD_OPC_SWI = 8'h83;
  localparam logic [7:0] CAD_OPC_TAX = 8'h97;
  localparam logic [7:0] CAD_OPC_TXA = 8'h9F;
  localparam logic [7:0] CAD_OPC_BSR = 8'hAD;
  // instruction lengths
  localparam logic [1:0] CAD_LEN1 = 2'h1;
  localparam logic [1:0] CAD_LEN2 = 2'h2;
  localparam logic [1:0] CAD_LEN3 = 2'h3;
  localparam logic [15:0] CAD_REL_STEP = 16'h0002;
  localparam logic [15:0] CAD_BTB_STEP = 16'h0003;
  // cycle counts
  localparam logic [3:0] CAD_CYC_IMM = 4'h2;
  localparam logic [3:0] CAD_CYC_DIR = 4'h3;
  localparam logic [3:0] CAD_CYC_EXT = 4'h4;
  localparam logic [3:0] CAD_CYC_IDX2 = 4'h5;
  localparam logic [3:0] CAD_CYC_IDX1 = 4'h4;
  localparam logic [3:0] CAD_CYC_IDX0 = 4'h2;
  localparam logic [3:0] CAD_CYC_RMW_DIR = 4'h4;
  localparam logic [3:0] CAD_CYC_RMW_REG = 4'h1;
  localparam logic [3:0] CAD_CYC_RMW_IDX1 = 4'h5;
  localparam logic [3:0] CAD_CYC_RMW_IDX0 = 4'h3;
  localparam logic [3:0] CAD_CYC_BR_NT = 4'h2;
  localparam logic [3:0] CAD_CYC_BR_T = 4'h3;
  localparam logic [3:0] CAD_CYC_BSR = 4'h4;
  localparam logic [3:0] CAD_CYC_BTB_NT = 4'h4;
  localparam logic [3:0] CAD_CYC_BTB_T = 4'h5;
  localparam logic [3:0] CAD_CYC_BSC = 4'h4;
  localparam logic [3:0] CAD_CYC_RTI = 4'h7;
  localparam logic [3:0] CAD_CYC_RTS = 4'h4;
  localparam logic [3:0] CAD_CYC_SWI = 4'h9;
  localparam logic [3:0] CAD_CYC_CTRL = 4'h1;
  localparam logic [3:0] CAD_CYC_UNDEF = 4'h1;
  // page-0 window of the port direction registers
  localparam logic [7:0] CAD_DDR_LO = 8'h04;
  localparam logic [7:0] CAD_DDR_HI = 8'h06;
endpackage

// ### test/cad_mem_model.sv
// program and page-0 data memory seen by the decoder
`timescale 1ns/1ps
module cad_mem_model (
  input wire logic [15:0] pc,
  output logic [7:0] opcode,
  output logic [7:0] operand1,
  output logic [7:0] operand2,
  output logic [7:0] tested_byte
);
  // only the low address byte decodes, so code and data share one page
  logic [7:0] mem [0:255];
  initial for (int k = 0; k < 256; k++) mem[k] = 8'h00;
  assign opcode = mem[pc[7:0]];
  assign operand1 = mem[8'(pc[7:0] + 8'h01)];
  assign operand2 = mem[8'(pc[7:0] + 8'h02)];
  assign tested_byte = mem[operand1];
endmodule

// ### test/testbench.sv
// self-checking bench: random and corner opcodes through the decoder
`timescale 1ns/1ps
module testbench;
  logic mclk, sys_rst, fetch_valid, irq_pin, dec_valid, pc_load, tk;
  logic branch_taken, mem_read, mem_write, acc_write, index_write;
  logic push_return, bit_value, carry_load, carry_value, undefined_op;
  logic [15:0] pc, effective_addr, next_pc, e_ea, e_np;
  logic [7:0] index_reg, opcode, operand1, operand2, tested_byte;
  logic [7:0] bit_mask, op, a, b, d, cv;
  logic [4:0] fl;
  logic [3:0] dec_op, cycle_count, hi, lo, c, m;
  logic [1:0] instr_len, ln;
  cad_pkg::cad_mode_e dec_mode;
  int error_cnt, tests_run, seed, i;
  logic [7:0] mo [10] = '{8'h3D, 8'h3C, 8'h7D, 8'h6C, 8'h82, 8'hA7,
    8'h31, 8'h97, 8'h9F, 8'h83};
  logic [15:0] ms [10] = '{16'h9200, 16'h9300, 16'h4E00, 16'h9700,
    16'h4410, 16'h4410, 16'h4410, 16'h4440, 16'h4480, 16'h6420};
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  cad_decoder DUT (.mclk(mclk), .sys_rst(sys_rst), .opcode(opcode),
    .fetch_valid(fetch_valid), .operand1(operand1), .operand2(operand2),
    .pc(pc), .index_reg(index_reg), .flag_half(fl[4]), .flag_neg(fl[2]),
    .flag_irq_mask(fl[3]), .flag_zero(fl[1]), .flag_carry(fl[0]),
    .irq_pin(irq_pin), .tested_byte(tested_byte), .dec_valid(dec_valid),
    .dec_mode(dec_mode), .dec_op(dec_op), .instr_len(instr_len),
    .cycle_count(cycle_count), .effective_addr(effective_addr),
    .next_pc(next_pc), .pc_load(pc_load), .branch_taken(branch_taken),
    .mem_read(mem_read), .mem_write(mem_write), .acc_write(acc_write),
    .index_write(index_write), .push_return(push_return),
    .bit_mask(bit_mask), .bit_value(bit_value), .carry_load(carry_load),
    .carry_value(carry_value), .undefined_op(undefined_op));
  cad_mem_model MEM (.pc(pc), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .tested_byte(tested_byte));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // new instruction each cycle; its decode is checked one edge later
  task automatic go(input logic [7:0] o, input logic [7:0] x,
      input logic [7:0] y);
    pc = {8'($random(seed)), 8'hF0};
    index_reg = 8'($random(seed));
    fl = 5'($random(seed));
    MEM.mem[8'hF0] = o;
    MEM.mem[8'hF1] = x;
    MEM.mem[8'hF2] = y;
    @(posedge mclk);
    #1;
    cmp({15'h0000, dec_valid}, 16'h0001);
  endtask
  task automatic give_verdict;
    $display("errors %0d in %0d comparisons", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    seed = 72078;
    error_cnt = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    fetch_valid = 1'b0;
    irq_pin = 1'b1;
    pc = 16'h0000;
    index_reg = 8'h00;
    fl = 5'h00;
    repeat (5) @(posedge mclk);
    #1;
    cmp({12'h000, dec_mode}, {12'h000, cad_pkg::CAD_M_UNDEF});
    sys_rst = 1'b0;
    fetch_valid = 1'b1;
    for (i = 0; i < 60; i++) begin
      hi = 4'hA + 4'(i % 6);
      lo = 4'($random(seed));
      // immediate store, jump and call do not exist
      if (hi == 4'hA && (lo == 4'h7 || (lo > 4'hB && lo != 4'hE)))
        lo = 4'h5;
      go({hi, lo}, 8'($random(seed)), 8'($random(seed)));
      ln = (hi == 4'hC || hi == 4'hD) ? 2'h3 : (hi == 4'hF ? 2'h1 : 2'h2);
      c = 4'(24'h24_5432 >> (4 * (hi - 4'hA)));
      m = 4'(24'h56_7321 >> (4 * (hi - 4'hA)));
      if (lo == 4'h7 || lo == 4'hF) c = c + 4'h1;
      if (lo == 4'hC && hi != 4'hF) c = c - 4'h1;
      if (lo == 4'hD && (hi == 4'hB || hi == 4'hC || hi == 4'hF))
        c = c + 4'h1;
      case (hi)
        4'hA: e_ea = pc + 16'h0001;
        4'hB: e_ea = {8'h00, operand1};
        4'hC: e_ea = {operand1, operand2};
        4'hD: e_ea = {operand1, operand2} + {8'h00, index_reg};
        4'hE: e_ea = {8'h00, operand1} + {8'h00, index_reg};
        default: e_ea = {8'h00, index_reg};
      endcase
      tk = lo == 4'hC || lo == 4'hD;
      e_np = tk ? e_ea : pc + {14'h0000, ln};
      cmp(effective_addr, e_ea);
      cmp(next_pc, e_np);
      cmp({dec_op, cycle_count, dec_mode, 2'h0, instr_len},
        {lo, c, m, 2'h0, ln});
      cmp({10'h000, mem_read, mem_write, acc_write, index_write,
        push_return, pc_load}, {10'h000, !(tk || lo == 4'h7 || lo == 4'hF),
        lo == 4'h7 || lo == 4'hF, cad_pkg::CAD_ACC_WRITE_OPS[lo],
        lo == 4'hE, lo == 4'hD, tk});
    end
    for (i = 0; i < 34; i++) begin
      // line low for the second pass of 2E/2F; sync lag is long over
      if (i == 20) irq_pin = 1'b0;
      op = (i > 31) ? 8'hAD : 8'h20 + 8'(i % 16);
      a = (i == 16) ? 8'h7F : ((i == 17) ? 8'h80 : 8'($random(seed)));
      go(op, a, 8'h00);
      cv = {~irq_pin, ~fl[3], ~fl[2], ~fl[4], ~fl[1], ~fl[0],
        ~(fl[0] | fl[1]), 1'b1};
      tk = (cv[op[3:1]] ^ op[0]) | (op == 8'hAD);
      e_np = pc + 16'h0002 + (tk ? {{8{a[7]}}, a} : 16'h0000);
      c = (op == 8'hAD) ? 4'h4 : (tk ? 4'h3 : 4'h2);
      cmp(next_pc, e_np);
      cmp({6'h00, dec_mode, branch_taken, push_return, cycle_count},
        {6'h00, cad_pkg::CAD_M_REL, tk, op == 8'hAD, c});
    end
    for (i = 0; i < 16; i++) begin
      a = 8'($random(seed)) & 8'h7F;
      b = (i < 2) ? 8'h80 : 8'($random(seed));
      d = 8'($random(seed));
      MEM.mem[a] = d;
      go(8'(i), a, b);
      tk = d[i / 2] ^ i[0];
      e_np = pc + 16'h0003 + (tk ? {{8{b[7]}}, b} : 16'h0000);
      cmp(effective_addr, {8'h00, a});
      cmp(next_pc, e_np);
      cmp({dec_mode, cycle_count, bit_mask}, {cad_pkg::CAD_M_BIT_TB,
        tk ? 4'h5 : 4'h4, 8'h01 << (i / 2)});
      cmp({13'h0000, carry_load, carry_value, branch_taken},
        {13'h0000, 1'b1, d[i / 2], tk});
    end
    for (i = 0; i < 32; i++) begin
      a = (i < 16) ? 8'h03 + 8'(i % 5) : 8'($random(seed)) & 8'h7F;
      go(8'h10 + 8'(i % 16), a, 8'h00);
      tk = a < 8'h04 || a > 8'h06;
      cmp(effective_addr, {8'h00, a});
      cmp({dec_mode, bit_mask, mem_read, mem_write, bit_value, 1'b0},
        {cad_pkg::CAD_M_BIT_SC, 8'h01 << ((i % 16) / 2), tk, tk, ~i[0],
        1'b0});
    end
    for (i = 0; i < 10; i++) begin
      go(mo[i], 8'($random(seed)) & 8'h7F, 8'h00);
      cmp({instr_len, cycle_count, mem_read, mem_write, acc_write,
        index_write, push_return, undefined_op, pc_load, 3'h0},
        ms[i]);
      cmp(next_pc, pc + {14'h0000, ms[i][15:14]});
    end
    give_verdict;
  end
endmodule
